// >>> logic/spims_pkg.sv
// spims_pkg: constants, mode codes and state type of the serial port.
// assumes a single 100 MHz clock that also serves as the oscillator rate.
`default_nettype none

package spims_pkg;

    // shift register width and last half-bit index per byte
    localparam int unsigned SPIMS_BYTE_BITS = 8;
    localparam logic [3:0] SPIMS_LAST_HALF = 4'hF;

    // role and rate codes in the low four control bits
    localparam logic [3:0] SPIMS_MODE_MASTER_DIV4 = 4'h0;
    localparam logic [3:0] SPIMS_MODE_MASTER_DIV16 = 4'h1;
    localparam logic [3:0] SPIMS_MODE_MASTER_DIV64 = 4'h2;
    localparam logic [3:0] SPIMS_MODE_MASTER_TMR2 = 4'h3;
    localparam logic [3:0] SPIMS_MODE_SLAVE_SEL = 4'h4;
    localparam logic [3:0] SPIMS_MODE_SLAVE_NOSEL = 4'h5;
    localparam logic [3:0] SPIMS_MODE_MASTER_RELOAD = 4'hA;

    // half bit times in clock cycles for the fixed master rates
    localparam logic [9:0] SPIMS_HALF_DIV4 = 10'h002;
    localparam logic [9:0] SPIMS_HALF_DIV16 = 10'h008;
    localparam logic [9:0] SPIMS_HALF_DIV64 = 10'h020;

    // receive stream buffer
    localparam int unsigned SPIMS_FIFO_DEPTH = 16;
    localparam int unsigned SPIMS_FIFO_WIDTH = 8;

    // reset values
    localparam logic [7:0] SPIMS_BUFFER_RESET = 8'h00;
    localparam logic [9:0] SPIMS_DIV_RESET = 10'h000;

    typedef struct packed {
        logic active;
        logic [3:0] half;
        logic [9:0] div;
        logic [7:0] shift;
        logic [7:0] buffer;
        logic samp;
        logic sdo;
        logic sck_level;
        logic sck_prev;
        logic buffer_full;
        logic write_collision_flag;
        logic irq;
    } spims_state_t;

endpackage

`default_nettype wire

// >>> logic/spims_port.sv
// spims_port: byte serial port, master or slave, with receive stream fifo.
// assumes all pins and strobes are synchronous to clock_in; the serial
// clock in slave role is sampled, so it must stay well below clock_in/4.
//
// Functional notes
// - completed byte goes to buffer, flag set
// - data write loads buffer and shifter together
// - mode, polarity, phase, edge, rate are inputs
// - enabled port owns pins, direction overrides
// - msb first; eight bits set full, flag
// - next byte may start before buffer read
// - busy write dropped, collision blocks later writes
// - buffer read clears the full flag
// - status low bits read only, top two writable
// - shifter reached only through data buffer
// - master may start a transfer any time; here a write is refused while the receive fifo is full
// - master write starts full duplex shifting
// - receive only master still delivers bytes
// - master rate: /4, /16, /64, timer, reload
// - reload value sets the baud divider
// - edge select set: data valid before edge
// - polarity sets idle level of clock
// - slave shifts on external clock edges
// - slave shifts in sleep, byte raises flag
// - overwrite enable accepts writes over unread byte
// - daisy chain slave echoes received byte
// - select low enables, high floats data out
// - port reset forces bit counter zero
// - shift on one edge, capture on other
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////
// stream fifo with valid and ready on both sides

module spims_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 16
) (
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int unsigned AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW:0] wr;
        logic [AW:0] rd;
    } spims_fifo_state_t;

    spims_fifo_state_t state_reg;
    spims_fifo_state_t state_next;
    logic [WIDTH-1:0] mem [DEPTH];
    logic full;
    logic empty;
    logic push;
    logic pop;

    assign full = (state_reg.wr[AW] != state_reg.rd[AW]) &&
                  (state_reg.wr[AW-1:0] == state_reg.rd[AW-1:0]);
    assign empty = state_reg.wr == state_reg.rd;
    assign push = in_valid_in && !full;
    assign pop = out_ready_in && !empty;
    assign in_ready_out = !full;
    assign out_valid_out = !empty;
    assign out_data_out = mem[state_reg.rd[AW-1:0]];

    always_comb begin
        state_next = state_reg;
        if (push) begin
            state_next.wr = state_reg.wr + 1'b1;
        end
        if (pop) begin
            state_next.rd = state_reg.rd + 1'b1;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clock_in) begin
        if (push) begin
            mem[state_reg.wr[AW-1:0]] <= in_data_in;
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////
// serial port top

module spims_port (
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic port_enable_bit_in,
    input wire logic [3:0] port_mode_in,
    input wire logic clock_polarity_bit_in,
    input wire logic clock_edge_select_in,
    input wire logic input_sample_phase_in,
    input wire logic buffer_overwrite_enable_in,
    input wire logic [7:0] rate_reload_reg_in,
    input wire logic timer2_tick_in,
    input wire logic data_write_in,
    input wire logic [7:0] data_write_value_in,
    input wire logic data_read_in,
    input wire logic write_collision_clear_in,
    input wire logic interrupt_flag_clear_in,
    output logic [7:0] data_buffer_out,
    output logic buffer_full_flag_out,
    output logic write_collision_flag_out,
    output logic port_interrupt_flag_out,
    output logic transfer_busy_out,
    input wire logic clock_dir_input_in,
    input wire logic data_out_dir_input_in,
    input wire logic serial_clock_pin_in,
    output logic serial_clock_pin_out,
    output logic serial_clock_pin_oe_out,
    input wire logic serial_data_in_pin_in,
    output logic serial_data_out_pin_out,
    output logic serial_data_out_pin_oe_out,
    input wire logic slave_select_pin_n_in,
    output logic rx_valid_out,
    input wire logic rx_ready_in,
    output logic [7:0] rx_data_out
);
    import spims_pkg::*;

    // master role decode, used by pins, writes and the engine
    function automatic logic spims_is_master(input logic [3:0] mode);
        spims_is_master = (mode == SPIMS_MODE_MASTER_DIV4) ||
                          (mode == SPIMS_MODE_MASTER_DIV16) ||
                          (mode == SPIMS_MODE_MASTER_DIV64) ||
                          (mode == SPIMS_MODE_MASTER_TMR2) ||
                          (mode == SPIMS_MODE_MASTER_RELOAD);
    endfunction

    // half bit length for the divider-based master rates
    function automatic logic [9:0] spims_half(input logic [3:0] mode,
                                               input logic [7:0] reload);
        case (mode)
            SPIMS_MODE_MASTER_DIV16: spims_half = SPIMS_HALF_DIV16;
            SPIMS_MODE_MASTER_DIV64: spims_half = SPIMS_HALF_DIV64;
            SPIMS_MODE_MASTER_RELOAD:
                spims_half = {1'b0, reload, 1'b0} + 10'h002;
            default: spims_half = SPIMS_HALF_DIV4;
        endcase
    endfunction

    spims_state_t state_reg;
    spims_state_t state_next;

    logic master;
    logic slave_selected;
    logic busy;
    logic write_ok;
    logic tick;
    logic edge_a;
    logic edge_b;
    logic byte_done;
    logic [7:0] byte_value;
    logic fifo_in_ready;
    logic sdi_now;

    assign master = spims_is_master(port_mode_in);
    // select gating only in select-controlled slave mode
    assign slave_selected = (port_mode_in != SPIMS_MODE_SLAVE_SEL) ||
                            !slave_select_pin_n_in;
    assign busy = master ? state_reg.active : (state_reg.half != 4'h0);
    assign sdi_now = serial_data_in_pin_in;

    ////////////////////////////////////////////////////////////////////////
    // rate divider and edge events

    always_comb begin
        tick = 1'b0;
        if (master && state_reg.active) begin
            if (port_mode_in == SPIMS_MODE_MASTER_TMR2) begin
                tick = timer2_tick_in;
            end else begin
                tick = state_reg.div == 10'h001;
            end
        end
    end

    always_comb begin
        edge_a = 1'b0;
        edge_b = 1'b0;
        if (port_enable_bit_in) begin
            if (master) begin
                edge_a = tick && !state_reg.half[0];
                edge_b = tick && state_reg.half[0];
            end else if (slave_selected) begin
                // idle to active and active to idle of the external clock
                edge_a = (state_reg.sck_prev == clock_polarity_bit_in) &&
                         (serial_clock_pin_in != clock_polarity_bit_in);
                edge_b = (state_reg.sck_prev != clock_polarity_bit_in) &&
                         (serial_clock_pin_in == clock_polarity_bit_in);
            end
        end
    end

    // the byte is complete at the closing edge of the eighth bit
    assign byte_done = edge_b && (state_reg.half == SPIMS_LAST_HALF);
    assign byte_value = {state_reg.shift[6:0],
                         (clock_edge_select_in && !input_sample_phase_in) ?
                         state_reg.samp : sdi_now};

    ////////////////////////////////////////////////////////////////////////
    // software data access

    always_comb begin
        write_ok = data_write_in && port_enable_bit_in && !state_reg.write_collision_flag &&
                   !busy;
        if (master && !fifo_in_ready) begin
            write_ok = 1'b0;
        end
        if (!master && state_reg.buffer_full &&
            !buffer_overwrite_enable_in) begin
            write_ok = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        state_next = state_reg;
        state_next.sck_prev = serial_clock_pin_in;

        if (master && state_reg.active) begin
            if (port_mode_in == SPIMS_MODE_MASTER_TMR2) begin
                state_next.div = SPIMS_DIV_RESET;
            end else if (tick) begin
                state_next.div = spims_half(port_mode_in, rate_reload_reg_in);
            end else begin
                state_next.div = state_reg.div - 10'h001;
            end
        end

        if (edge_a) begin
            state_next.half = state_reg.half + 4'h1;
            if (clock_edge_select_in) begin
                state_next.samp = sdi_now;
            end else begin
                state_next.sdo = state_reg.shift[7];
            end
        end

        if (edge_b) begin
            state_next.half = state_reg.half + 4'h1;
            // msb leaves first, new lsb enters
            state_next.shift = byte_value;
            if (clock_edge_select_in) begin
                state_next.sdo = state_reg.shift[6];
            end
        end

        if (byte_done) begin
            state_next.half = 4'h0;
            state_next.active = 1'b0;
            state_next.buffer = byte_value;
            state_next.buffer_full = 1'b1;
            state_next.irq = 1'b1;
        end else if (data_read_in) begin
            state_next.buffer_full = 1'b0;
        end

        if (interrupt_flag_clear_in && !byte_done) begin
            state_next.irq = 1'b0;
        end

        if (data_write_in && port_enable_bit_in && !write_ok &&
            !state_reg.write_collision_flag) begin
            state_next.write_collision_flag = 1'b1;
        end else if (write_collision_clear_in) begin
            state_next.write_collision_flag = 1'b0;
        end

        if (write_ok) begin
            // one register feeds both buffer and shifter
            state_next.buffer = data_write_value_in;
            state_next.shift = data_write_value_in;
            state_next.sdo = data_write_value_in[7];
            state_next.half = 4'h0;
            if (master) begin
                state_next.active = 1'b1;
                state_next.div = spims_half(port_mode_in, rate_reload_reg_in);
            end
        end

        // master clock level follows the half index
        state_next.sck_level = clock_polarity_bit_in ^
                               (state_next.active & state_next.half[0]);

        if (!port_enable_bit_in || (!master && !slave_selected)) begin
            // port reset clears the bit position
            state_next.half = 4'h0;
            state_next.active = 1'b0;
            state_next.div = SPIMS_DIV_RESET;
            state_next.sck_level = clock_polarity_bit_in;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            state_reg <= '0;
            state_reg.buffer <= SPIMS_BUFFER_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // receive stream buffer; a full fifo holds off master starts

    spims_fifo #(
        .WIDTH(SPIMS_FIFO_WIDTH),
        .DEPTH(SPIMS_FIFO_DEPTH)
    ) u_rx_fifo (
        .clock_in(clock_in),
        .resetn_in(resetn_in),
        .in_valid_in(byte_done),
        .in_ready_out(fifo_in_ready),
        .in_data_in(byte_value),
        .out_valid_out(rx_valid_out),
        .out_ready_in(rx_ready_in),
        .out_data_out(rx_data_out)
    );

    ////////////////////////////////////////////////////////////////////////
    // pins and status

    // enabled master takes the clock pin, enabled master or selected slave the data out pin, unless direction says input
    assign serial_clock_pin_out = state_reg.sck_level;
    assign serial_clock_pin_oe_out = port_enable_bit_in && master &&
                                     !clock_dir_input_in;
    assign serial_data_out_pin_out = state_reg.sdo;
    assign serial_data_out_pin_oe_out = port_enable_bit_in &&
                                        !data_out_dir_input_in &&
                                        (master || slave_selected);

    assign data_buffer_out = state_reg.buffer;
    assign buffer_full_flag_out = state_reg.buffer_full;
    assign write_collision_flag_out = state_reg.write_collision_flag;
    assign port_interrupt_flag_out = state_reg.irq;
    assign transfer_busy_out = busy;
endmodule

`default_nettype wire

// >>> sim/spims_far_slave.sv
// spims_far_slave: serial slave facing the port in master role.
// assumes an idle-low clock, data changed on falling and taken on rising.
`timescale 1ns/1ps
`default_nettype none

module spims_far_slave (
    input wire logic sck_in,
    input wire logic sel_n_in,
    input wire logic data_in,
    input wire logic [7:0] tx_in,
    output logic data_out,
    output logic [7:0] rx_out
);
    logic [7:0] sh_reg;
    initial data_out = 1'h0;
    initial rx_out = 8'h00;
    always @(negedge sel_n_in) begin
        sh_reg = tx_in;
        data_out = tx_in[7];
    end
    always @(posedge sck_in) begin
        if (!sel_n_in) rx_out = {rx_out[6:0], data_in};
    end
    always @(negedge sck_in) begin
        if (!sel_n_in) begin
            sh_reg = {sh_reg[6:0], 1'h0};
            data_out = sh_reg[7];
        end
    end
    // released line shows the inverse of its last value
    always @(posedge sel_n_in) data_out = ~data_out;
endmodule

`default_nettype wire

// >>> sim/spims_port_assertions.sv
// spims_port_assertions: port-level checks of the serial port.
// assumes the mode codes of spims_pkg and the write rules of spims_port.
`timescale 1ns/1ps
`default_nettype none

module spims_port_checker (
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic port_enable_bit_in,
    input wire logic [3:0] port_mode_in,
    input wire logic data_write_in,
    input wire logic [7:0] data_write_value_in,
    input wire logic data_read_in,
    input wire logic write_collision_clear_in,
    input wire logic [7:0] data_buffer_out,
    input wire logic buffer_full_flag_out,
    input wire logic write_collision_flag_out,
    input wire logic port_interrupt_flag_out,
    input wire logic transfer_busy_out,
    input wire logic clock_dir_input_in,
    input wire logic data_out_dir_input_in,
    input wire logic serial_clock_pin_oe_out,
    input wire logic serial_data_out_pin_oe_out,
    input wire logic slave_select_pin_n_in,
    input wire logic rx_valid_out
);
    logic master;
    logic go;
    assign master = port_mode_in inside {4'h0, 4'h1, 4'h2, 4'h3, 4'hA};
    assign go = data_write_in && port_enable_bit_in;
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!resetn_in);

    property p_sck_oe;
        serial_clock_pin_oe_out ==
            (port_enable_bit_in && master && !clock_dir_input_in);
    endproperty
    a_sck_oe: assert property (p_sck_oe)
        else $error("clock enable wrong");
    property p_sdo_float;
        (data_out_dir_input_in || (port_mode_in == 4'h4 &&
            slave_select_pin_n_in)) |-> !serial_data_out_pin_oe_out;
    endproperty
    a_sdo_float: assert property (p_sdo_float)
        else $error("data out driven");
    property p_write_loads;
        go && !write_collision_flag_out && !transfer_busy_out |=>
            write_collision_flag_out ||
            data_buffer_out == $past(data_write_value_in);
    endproperty
    a_write_loads: assert property (p_write_loads)
        else $error("write not loaded");
    property p_busy_collide;
        go && transfer_busy_out &&
            !(write_collision_flag_out && write_collision_clear_in) |=>
            write_collision_flag_out;
    endproperty
    a_busy_collide: assert property (p_busy_collide)
        else $error("busy write no collision");
    property p_write_collision_flag_blocks;
        go && write_collision_flag_out && !write_collision_clear_in &&
            !transfer_busy_out |=> $stable(data_buffer_out);
    endproperty
    a_write_collision_flag_blocks: assert property (p_write_collision_flag_blocks)
        else $error("blocked write took effect");
    property p_read_clears;
        data_read_in && !transfer_busy_out |=> !buffer_full_flag_out;
    endproperty
    a_read_clears: assert property (p_read_clears)
        else $error("read left full set");
    property p_flags;
        $rose(buffer_full_flag_out) |-> port_interrupt_flag_out &&
            rx_valid_out;
    endproperty
    a_flags: assert property (p_flags)
        else $error("byte flags apart");
    property p_master_len;
        $rose(transfer_busy_out) && port_mode_in == 4'h0 |->
            transfer_busy_out [*8] ##[20:28] !transfer_busy_out;
    endproperty
    a_master_len: assert property (p_master_len)
        else $error("byte length wrong");
    c_master: cover property ($fell(transfer_busy_out) && master);
    c_write_collision_flag: cover property ($rose(write_collision_flag_out));
    c_slave: cover property ($rose(port_interrupt_flag_out) && !master);
endmodule

bind spims_port spims_port_checker spims_port_checker_i (.clock_in,
    .resetn_in, .port_enable_bit_in, .port_mode_in, .data_write_in,
    .data_write_value_in, .data_read_in, .write_collision_clear_in,
    .data_buffer_out, .buffer_full_flag_out, .write_collision_flag_out,
    .port_interrupt_flag_out, .transfer_busy_out, .clock_dir_input_in,
    .data_out_dir_input_in, .serial_clock_pin_oe_out,
    .serial_data_out_pin_oe_out, .slave_select_pin_n_in, .rx_valid_out);

`default_nettype wire

// >>> sim/spims_port_bench.sv
// spims_port_bench: self-checking bench of the serial port.
// assumes spims_pkg, spims_port and spims_far_slave are compiled first.
`timescale 1ns/1ps
`default_nettype none

module spims_port_bench;
    import spims_pkg::*;
    logic clk = 1'h0, rstn = 1'h0, en = 1'h0, buffer_overwrite_enable = 1'h0, tick = 1'h0;
    logic wr = 1'h0, rd = 1'h0, wclr = 1'h0, iclr = 1'h0, dodir = 1'h0;
    logic tsck = 1'h0, tsdi = 1'h0, ssn = 1'h1, rdy = 1'h1, fsel_n = 1'h1;
    logic flip = 1'h0, ckdir = 1'h0;
    logic [3:0] mode = 4'h0;
    logic [2:0] tcnt = 3'h0;
    logic [7:0] wval = 8'h00, ftx = 8'h00;
    logic [7:0] buf_q, rx_q, frx;
    logic full, write_collision_flag, irq, busy, sck_q, sck_oe, sdo_q, sdo_oe, rxv, fsdo;
    logic sck_w, sdi_w, sdo_w;
    int mismatches = 0;
    int checked = 0;
    assign sck_w = sck_oe ? sck_q : tsck;
    assign sdo_w = sdo_oe ? sdo_q : flip;
    assign sdi_w = (mode == SPIMS_MODE_SLAVE_SEL) ? tsdi : fsdo;

    initial forever #5 clk = ~clk;
    always @(posedge clk) begin
        flip <= ~flip;
        tcnt <= (tcnt == 3'h4) ? 3'h0 : tcnt + 3'h1;
        tick <= (tcnt == 3'h4);
    end

    spims_port spims_port_i (
        .clock_in(clk), .resetn_in(rstn), .port_enable_bit_in(en),
        .port_mode_in(mode), .clock_polarity_bit_in(1'h0),
        .clock_edge_select_in(1'h1), .input_sample_phase_in(1'h0),
        .buffer_overwrite_enable_in(buffer_overwrite_enable), .rate_reload_reg_in(8'h03),
        .timer2_tick_in(tick), .data_write_in(wr),
        .data_write_value_in(wval), .data_read_in(rd),
        .write_collision_clear_in(wclr), .interrupt_flag_clear_in(iclr),
        .data_buffer_out(buf_q), .buffer_full_flag_out(full),
        .write_collision_flag_out(write_collision_flag), .port_interrupt_flag_out(irq),
        .transfer_busy_out(busy), .clock_dir_input_in(ckdir),
        .data_out_dir_input_in(dodir), .serial_clock_pin_in(sck_w),
        .serial_clock_pin_out(sck_q), .serial_clock_pin_oe_out(sck_oe),
        .serial_data_in_pin_in(sdi_w), .serial_data_out_pin_out(sdo_q),
        .serial_data_out_pin_oe_out(sdo_oe),
        .slave_select_pin_n_in(ssn), .rx_valid_out(rxv),
        .rx_ready_in(rdy), .rx_data_out(rx_q));
    spims_far_slave spims_far_slave_i (.sck_in(sck_w), .sel_n_in(fsel_n),
        .data_in(sdo_w), .tx_in(ftx), .data_out(fsdo), .rx_out(frx));

    ////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e,
                       input logic [7:0] s);
        checked++;
        if (s !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr_byte(input logic [7:0] v);
        @(posedge clk);
        wr <= 1'h1;
        wval <= v;
        @(posedge clk);
        wr <= 1'h0;
        #1;
    endtask
    // 0 read, 1 collision clear, 2 flag clear
    task automatic pulse(input int k);
        @(posedge clk);
        rd <= (k == 0);
        wclr <= (k == 1);
        iclr <= (k == 2);
        @(posedge clk);
        rd <= 1'h0;
        wclr <= 1'h0;
        iclr <= 1'h0;
        #1;
    endtask
    task automatic give_up(input string n);
        mismatches++;
        $display("BAD %s expected done seen timeout", n);
        end_sim();
    endtask
    task automatic wait_idle();
        int i;
        i = 0;
        while (busy !== 1'h0 && i < 3000) begin
            @(posedge clk);
            #1;
            i++;
        end
        if (busy !== 1'h0) begin
            give_up("busy");
        end
    endtask
    task automatic cfg(input logic [3:0] m);
        @(posedge clk);
        en <= 1'h0;
        @(posedge clk);
        mode <= m;
        @(posedge clk);
        en <= 1'h1;
    endtask
    task automatic m_xfer(input logic [7:0] tx, input logic [7:0] fb);
        @(posedge clk);
        ftx <= fb;
        fsel_n <= 1'h0;
        wr_byte(tx);
        wait_idle();
        @(posedge clk);
        fsel_n <= 1'h1;
    endtask
    task automatic s_byte(input logic [7:0] v, input int nb,
                          output logic [7:0] g);
        int i;
        g = 8'h00;
        @(posedge clk);
        ssn <= 1'h0;
        for (i = 7; i > 7 - nb; i--) begin
            tsdi <= v[i];
            repeat (4) @(posedge clk);
            tsck <= 1'h1;
            g = {g[6:0], sdo_w};
            repeat (4) @(posedge clk);
            tsck <= 1'h0;
        end
        repeat (4) @(posedge clk);
        ssn <= 1'h1;
        tsdi <= ~tsdi;
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_master();
        cfg(SPIMS_MODE_MASTER_DIV4);
        m_xfer(8'hA5, 8'h3C);
        chk("far_rx", 8'hA5, frx);
        chk("buffer", 8'h3C, buf_q);
        chk("full", 8'h01, 8'(full));
        chk("irq", 8'h01, 8'(irq));
        pulse(0);
        chk("full_read", 8'h00, 8'(full));
    endtask
    task automatic t_collide();
        @(posedge clk);
        ftx <= 8'h66;
        fsel_n <= 1'h0;
        wr_byte(8'h11);
        chk("buf_write", 8'h11, buf_q);
        wr_byte(8'h22);
        chk("write_collision_flag_busy", 8'h01, 8'(write_collision_flag));
        wait_idle();
        chk("buf_keep", 8'h66, buf_q);
        wr_byte(8'h33);
        chk("write_collision_flag_block", 8'h66, buf_q);
        pulse(1);
        chk("write_collision_flag_clear", 8'h00, 8'(write_collision_flag));
        fsel_n <= 1'h1;
    endtask
    task automatic t_rate(input logic [3:0] m, input int h, input logic ro);
        int n;
        cfg(m);
        dodir <= ro;
        @(posedge clk);
        ftx <= 8'h81;
        fsel_n <= 1'h0;
        wr_byte(8'hC3);
        n = 0;
        while (sck_w !== 1'h1 && n < 200) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (sck_w !== 1'h1) begin
            give_up("sck_rise");
        end
        n = 0;
        while (sck_w === 1'h1 && n < 200) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (sck_w === 1'h1) begin
            give_up("sck_fall");
        end
        chk("half_bit", 8'(h), 8'(n));
        wait_idle();
        chk("rate_buf", 8'h81, buf_q);
        chk("sdo_oe", 8'(!ro), 8'(sdo_oe));
        @(posedge clk);
        fsel_n <= 1'h1;
        dodir <= 1'h0;
    endtask
    task automatic t_fifo();
        int i;
        cfg(SPIMS_MODE_MASTER_DIV4);
        rdy <= 1'h0;
        for (i = 0; i < 16; i++) m_xfer(8'h00, 8'h40 + 8'(i));
        chk("last_buf", 8'h4F, buf_q);
        wr_byte(8'hEE);
        chk("fifo_write_collision_flag", 8'h01, 8'(write_collision_flag));
        pulse(1);
        for (i = 0; i < 16; i++) begin
            chk("fifo_valid", 8'h01, 8'(rxv));
            chk("fifo_data", 8'h40 + 8'(i), rx_q);
            @(posedge clk);
            rdy <= 1'h1;
            @(posedge clk);
            rdy <= 1'h0;
            #1;
        end
        chk("fifo_empty", 8'h00, 8'(rxv));
        @(posedge clk);
        rdy <= 1'h1;
    endtask
    task automatic t_slave();
        logic [7:0] g;
        cfg(SPIMS_MODE_SLAVE_SEL);
        ckdir <= 1'h1;
        pulse(0);
        pulse(2);
        chk("irq_clear", 8'h00, 8'(irq));
        wr_byte(8'h96);
        s_byte(8'h5A, 8, g);
        chk("slave_out", 8'h96, g);
        chk("slave_buf", 8'h5A, buf_q);
        chk("slave_irq", 8'h01, 8'(irq));
        wr_byte(8'h77);
        chk("unread_write_collision_flag", 8'h01, 8'(write_collision_flag));
        pulse(1);
        @(posedge clk);
        buffer_overwrite_enable <= 1'h1;
        wr_byte(8'hC7);
        chk("overwrite", 8'hC7, buf_q);
        s_byte(8'hE1, 8, g);
        chk("over_out", 8'hC7, g);
        s_byte(8'h18, 8, g);
        chk("daisy", 8'hE1, g);
        s_byte(8'hFF, 3, g);
        chk("float", 8'h00, 8'(sdo_oe));
        s_byte(8'h3C, 8, g);
        chk("resync", 8'h3C, buf_q);
    endtask

    initial begin
        repeat (20) @(posedge clk);
        rstn <= 1'h1;
        t_master();
        t_collide();
        t_rate(SPIMS_MODE_MASTER_DIV4, 2, 1'h0);
        t_rate(SPIMS_MODE_MASTER_DIV16, 8, 1'h0);
        t_rate(SPIMS_MODE_MASTER_DIV64, 32, 1'h0);
        t_rate(SPIMS_MODE_MASTER_TMR2, 5, 1'h1);
        t_rate(SPIMS_MODE_MASTER_RELOAD, 8, 1'h0);
        t_fifo();
        t_slave();
        end_sim();
    end
endmodule

`default_nettype wire
